// [rtl/ascan_pick.sv]
`timescale 1ns/10ps
module ascan_pick import ascan_pkg::*; #(
   parameter int N = ASCAN_NSEL
) (
   // selection
   input  wire logic [N-1:0]           mask,
   input  wire logic [ASCAN_IDX_W-1:0] cur,
   input  wire logic                   from_start,
   // result
   output logic      [ASCAN_IDX_W-1:0] nxt,
   output logic                        found,
   output logic                        wrapped
);

   logic [ASCAN_IDX_W-1:0] hi_idx;
   logic                   hi_found;

   // descending walk leaves the lowest hit in each result
   always_comb begin
      nxt      = '0;
      found    = 1'b0;
      hi_idx   = '0;
      hi_found = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (mask[i]) begin
            nxt   = ASCAN_IDX_W'(i);
            found = 1'b1;
            if (from_start || ASCAN_IDX_W'(i) > cur) begin
               hi_idx   = ASCAN_IDX_W'(i);
               hi_found = 1'b1;
            end
         end
      end
      wrapped = found && !hi_found;
      if (hi_found) begin
         nxt = hi_idx;
      end
   end

endmodule

// [rtl/ascan_pkg.sv]
package ascan_pkg;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [3:0]  ASCAN_OFS_LOW    = 4'h0;
   localparam logic [3:0]  ASCAN_OFS_HIGH   = 4'h4;
   localparam logic [3:0]  ASCAN_OFS_CTRL   = 4'h8;
   localparam logic [3:0]  ASCAN_OFS_STATUS = 4'hC;
   localparam int          ASCAN_ADDR_W     = 4;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int          ASCAN_LOW_W      = 32;
   localparam int          ASCAN_HIGH_W     = 19;
   localparam int          ASCAN_NSEL       = 51;
   localparam int          ASCAN_IDX_W      = 6;
   localparam int          ASCAN_CTRL_EN    = 0;
   localparam int          ASCAN_ST_VALID   = 8;
   localparam int          ASCAN_ST_SRC     = 9;
   localparam logic [31:0] ASCAN_LOW_RST    = 32'h0000_0000;
   localparam logic [18:0] ASCAN_HIGH_RST   = 19'h0_0000;

   // ************************************************************
   // internal source positions per package variant
   // ************************************************************
   localparam logic [5:0]  ASCAN_INT_BASE_64  = 6'h1C;
   localparam logic [5:0]  ASCAN_INT_BASE_100 = 6'h30;
   localparam int          ASCAN_EXT_64       = 28;
   localparam int          ASCAN_EXT_100      = 48;

   localparam logic [1:0]  ASCAN_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  ASCAN_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ASCAN_SRC_PIN,
      ASCAN_SRC_BANDGAP,
      ASCAN_SRC_TEMP,
      ASCAN_SRC_CHARGE_TIME_UNIT,
      ASCAN_SRC_LOWREF
   } ascan_src_t;

endpackage

// [rtl/ascan_top.sv]
//
// Contract
// - low mask bit x selects input x, 0-31
// - high mask bits 18-0 select inputs 32-50
// - cleared mask bit skips that input entirely
// - 64-pin: bits 28-30 pick internal sources
// - 100-pin: bits 48-50 pick internal sources
// - all bits writable; absent inputs convert low reference
// - high register bits 31-19 read zero
// - high mask only meaningful on 100-pin parts
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module ascan_top import ascan_pkg::*; #(
   parameter bit PINS_100 = 1'b1,
   parameter int EXT_64   = ASCAN_EXT_64,
   parameter int EXT_100  = ASCAN_EXT_100
) (
   // clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // axi4-lite write address
   input  wire logic [ASCAN_ADDR_W-1:0] awaddr,
   input  wire logic [2:0]              awprot,
   input  wire logic                    awvalid,
   output logic                         awready,
   // axi4-lite write data
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   // axi4-lite write response
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // axi4-lite read
   input  wire logic [ASCAN_ADDR_W-1:0] araddr,
   input  wire logic [2:0]              arprot,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   // conversion engine
   input  wire logic                    conv_req,
   output logic [ASCAN_IDX_W-1:0]       scan_chan,
   output ascan_src_t                   scan_src,
   output logic                         scan_valid
);

   // ************************************************************
   // state
   // ************************************************************
   logic [ASCAN_LOW_W-1:0]  sel_low_q;
   logic [ASCAN_HIGH_W-1:0] sel_high_q;
   logic                    scan_en_q;
   logic                    started_q;
   logic [ASCAN_IDX_W-1:0]  chan_q;
   ascan_src_t              src_q;
   logic                    valid_q;
   logic                    awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic                    aw_have_q, w_have_q;
   logic [ASCAN_ADDR_W-1:0] waddr_q;
   logic [31:0]             wdata_q;
   logic [3:0]              wstrb_q;
   logic [1:0]              bresp_q, rresp_q;
   logic [31:0]             rdata_q;
   logic [ASCAN_NSEL-1:0]   eff_mask;
   logic [ASCAN_NSEL-1:0]   mask_seen_q;
   logic [ASCAN_IDX_W-1:0]  pick_nxt;
   logic                    pick_found;
   logic                    pick_wrap;
   logic                    do_write;
   logic                    scan_step;

   // ************************************************************
   // source routing per variant
   // ************************************************************
   function automatic ascan_src_t classify(input logic [ASCAN_IDX_W-1:0] idx);
      logic [ASCAN_IDX_W-1:0] base;
      int                     ext;
      base = PINS_100 ? ASCAN_INT_BASE_100 : ASCAN_INT_BASE_64;
      ext  = PINS_100 ? EXT_100 : EXT_64;
      if (idx == base) begin
         classify = ASCAN_SRC_BANDGAP;
      end else if (idx == base + 6'h1) begin
         classify = ASCAN_SRC_TEMP;
      end else if (idx == base + 6'h2) begin
         classify = ASCAN_SRC_CHARGE_TIME_UNIT;
      end else if (32'(idx) >= ext) begin
         classify = ASCAN_SRC_LOWREF;
      end else begin
         classify = ASCAN_SRC_PIN;
      end
   endfunction

   // small parts have no inputs behind the upper mask, so it is ignored there
   assign eff_mask = {(PINS_100 ? sel_high_q : ASCAN_HIGH_RST), sel_low_q};

   ascan_pick #(
      .N          (ASCAN_NSEL)
   ) u_pick (
      .mask       (eff_mask),
      .cur        (chan_q),
      .from_start (!started_q),
      .nxt        (pick_nxt),
      .found      (pick_found),
      .wrapped    (pick_wrap)
   );

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   assign do_write = aw_have_q && w_have_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= ASCAN_RESP_OKAY;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         awready_q <= !aw_have_q && !(awvalid && awready_q) && !bvalid_q;
         wready_q  <= !w_have_q && !(wvalid && wready_q) && !bvalid_q;
         if (awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            waddr_q   <= awaddr;
         end
         if (wvalid && wready_q) begin
            w_have_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (waddr_q == ASCAN_OFS_STATUS || waddr_q[1:0] != 2'h0) ?
                        ASCAN_RESP_SLVERR : ASCAN_RESP_OKAY;
         end else if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
      end
   end

   // mask registers, written lane by lane
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_low_q  <= ASCAN_LOW_RST;
         sel_high_q <= ASCAN_HIGH_RST;
         scan_en_q  <= 1'b0;
      end else if (do_write) begin
         for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b] && waddr_q == ASCAN_OFS_LOW) begin
               sel_low_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            end
         end
         if (waddr_q == ASCAN_OFS_HIGH) begin
            // only 19 bits exist; lane 3 and bits 23-19 of lane 2 are dropped
            if (wstrb_q[0]) sel_high_q[7:0]   <= wdata_q[7:0];
            if (wstrb_q[1]) sel_high_q[15:8]  <= wdata_q[15:8];
            if (wstrb_q[2]) sel_high_q[18:16] <= wdata_q[18:16];
         end
         if (waddr_q == ASCAN_OFS_CTRL && wstrb_q[0]) begin
            scan_en_q <= wdata_q[ASCAN_CTRL_EN];
         end
      end
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= ASCAN_RESP_OKAY;
      end else begin
         arready_q <= !rvalid_q && !(arvalid && arready_q);
         if (arvalid && arready_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= ASCAN_RESP_OKAY;
            unique case (araddr)
               ASCAN_OFS_LOW: begin
                  rdata_q <= sel_low_q;
               end
               ASCAN_OFS_HIGH: begin
                  rdata_q <= {13'h0000, sel_high_q};
               end
               ASCAN_OFS_CTRL: begin
                  rdata_q <= {31'h0000_0000, scan_en_q};
               end
               ASCAN_OFS_STATUS: begin
                  rdata_q <= {20'h0_0000, src_q, valid_q, 2'h0, chan_q};
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= ASCAN_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // scan sequencer
   // ************************************************************
   assign scan_step = conv_req && scan_en_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         started_q <= 1'b0;
         chan_q    <= '0;
         src_q     <= ASCAN_SRC_PIN;
         valid_q   <= 1'b0;
      end else if (!scan_en_q) begin
         // disabling restarts the walk from the lowest input
         started_q <= 1'b0;
         valid_q   <= 1'b0;
      end else if (scan_step) begin
         if (pick_found) begin
            chan_q    <= pick_nxt;
            src_q     <= classify(pick_nxt);
            valid_q   <= 1'b1;
            started_q <= 1'b1;
         end else begin
            valid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      mask_seen_q <= eff_mask;
   end

   assign awready    = awready_q;
   assign wready     = wready_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = arready_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign scan_chan  = chan_q;
   assign scan_src   = src_q;
   assign scan_valid = valid_q;

   // ************************************************************
   // checks
   // ************************************************************
   sel_low_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_step && pick_found && pick_nxt < 6'h20 |=> valid_q && mask_seen_q[chan_q])
      else $error("scanned low input not selected");

   sel_high_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_step && pick_found && pick_nxt >= 6'h20
      |=> valid_q && chan_q <= 6'h32 && mask_seen_q[chan_q])
      else $error("scanned high input not selected");

   skip_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_step && eff_mask == '0 |=> !valid_q)
      else $error("conversion issued with empty mask");

   int_src_64_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !PINS_100 && valid_q && chan_q == 6'h1D |-> src_q == ASCAN_SRC_TEMP)
      else $error("64-pin temperature diode misrouted");

   int_src_100_a: assert property (@(posedge aclk) disable iff (!aresetn)
      PINS_100 && valid_q && chan_q == 6'h32 |-> src_q == ASCAN_SRC_CHARGE_TIME_UNIT)
      else $error("100-pin charge-time input misrouted");

   low_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
      valid_q && chan_q == 6'h1F && !PINS_100 |-> src_q == ASCAN_SRC_LOWREF)
      else $error("absent input not on low reference");

   high_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready_q && araddr == ASCAN_OFS_HIGH |=> rvalid_q && rdata_q[31:19] == '0)
      else $error("reserved high bits read nonzero");

   small_part_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !PINS_100 && valid_q |-> chan_q < 6'h20)
      else $error("upper mask used on small part");

   order_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_step && started_q && pick_found && !pick_wrap |=> chan_q > $past(chan_q))
      else $error("scan order not ascending");

endmodule

// [tb/test_adc_scan_input_select.sv]
`timescale 1ns/10ps
module test_adc_scan_input_select import ascan_pkg::*;;

   // ************************************************************
   // clock, bus and scan stimulus
   // ************************************************************
   logic                    aclk;
   logic                    aresetn;
   logic [ASCAN_ADDR_W-1:0] awaddr;
   logic                    awvalid;
   logic                    awready;
   logic [31:0]             wdata;
   logic [3:0]              wstrb;
   logic                    wvalid;
   logic                    wready;
   logic [1:0]              bresp;
   logic                    bvalid;
   logic                    bready;
   logic [ASCAN_ADDR_W-1:0] araddr;
   logic                    arvalid;
   logic                    arready;
   logic [31:0]             rdata;
   logic [1:0]              rresp;
   logic                    rvalid;
   logic                    rready;
   logic                    conv_req;
   logic [ASCAN_IDX_W-1:0]  scan_chan;
   ascan_src_t              scan_src;
   logic                    scan_valid;
   logic [ASCAN_IDX_W-1:0]  scan_chan_s;
   ascan_src_t              scan_src_s;
   logic                    scan_valid_s;
   int                      n_errors;
   int                      comparisons;
   logic [5:0]              seq1 [9] = '{6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20,
                                         6'h30, 6'h31, 6'h32, 6'h1C};

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ************************************************************
   // two variants share the bus; only the large one answers it
   // ************************************************************
   ascan_top ascan_top_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .conv_req(conv_req), .scan_chan(scan_chan),
      .scan_src(scan_src), .scan_valid(scan_valid));

   ascan_top #(.PINS_100(1'b0)) small_ascan_top_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(),
      .rdata(), .rresp(), .rvalid(), .rready(rready), .conv_req(conv_req),
      .scan_chan(scan_chan_s), .scan_src(scan_src_s), .scan_valid(scan_valid_s));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_done;
      bit w_done;
      int t;
      @(posedge aclk);
      aw_done = 1'b0;
      w_done = 1'b0;
      t = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done) && t < 200) begin
         @(posedge aclk);
         t++;
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // bready stays up until the answer is sampled
      do begin
         @(posedge aclk);
         t++;
      end while (!bvalid && t < 400);
      // a wait that ran out shows up here as a missing response
      check(32'(bvalid), 32'h1);
      check(32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask

   task automatic read_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int t;
      @(posedge aclk);
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (!arready && t < 200);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         t++;
      end while (!rvalid && t < 400);
      check(32'(rvalid), 32'h1);
      check(rdata, ed);
      check(32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask

   // one conversion request; both variants step together
   task automatic step(input logic v, input logic [5:0] c1, input ascan_src_t s1,
                       input logic [5:0] c2, input ascan_src_t s2);
      @(posedge aclk);
      conv_req <= 1'b1;
      @(posedge aclk);
      conv_req <= 1'b0;
      #1;
      check(32'(scan_valid), 32'(v));
      check(32'(scan_valid_s), 32'(v));
      if (v) begin
         check(32'(scan_chan), 32'(c1));
         check(32'(scan_src), 32'(s1));
         check(32'(scan_chan_s), 32'(c2));
         check(32'(scan_src_s), 32'(s2));
      end
   endtask

   task automatic tally_and_finish;
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      n_errors = 0;
      comparisons = 0;
      aresetn = 1'b0;
      awaddr = 4'h0;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 4'h0;
      arvalid = 1'b0;
      rready = 1'b0;
      conv_req = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      check(32'(scan_valid), 32'h0);
      read_chk(ASCAN_OFS_LOW, 32'h0, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_HIGH, 32'h0, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_LOW, 32'hFFFF_FFFF, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_LOW, 32'hFFFF_FFFF, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_HIGH, 32'hFFFF_FFFF, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_HIGH, 32'h0007_FFFF, ASCAN_RESP_OKAY);
      // byte lanes: only the strobed lane of the low mask changes
      wstrb <= 4'h2;
      axi_write(ASCAN_OFS_LOW, 32'h0000_0000, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_LOW, 32'hFFFF_00FF, ASCAN_RESP_OKAY);
      // top lane of the high mask is not there; lane 2 keeps bits 18-16 only
      wstrb <= 4'hC;
      axi_write(ASCAN_OFS_HIGH, 32'hFF00_0000, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_HIGH, 32'h0000_FFFF, ASCAN_RESP_OKAY);
      wstrb <= 4'hF;
      axi_write(ASCAN_OFS_STATUS, 32'h1, ASCAN_RESP_SLVERR);
      read_chk(4'h2, 32'h0, ASCAN_RESP_SLVERR);
      axi_write(ASCAN_OFS_LOW, 32'h0000_0005, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_HIGH, 32'h0, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_CTRL, 32'h1, ASCAN_RESP_OKAY);
      step(1'b1, 6'h00, ASCAN_SRC_PIN, 6'h00, ASCAN_SRC_PIN);
      step(1'b1, 6'h02, ASCAN_SRC_PIN, 6'h02, ASCAN_SRC_PIN);
      step(1'b1, 6'h00, ASCAN_SRC_PIN, 6'h00, ASCAN_SRC_PIN);
      // inputs 28-32 and 48-50; the small variant sees only 28-31
      axi_write(ASCAN_OFS_LOW, 32'hF000_0000, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_HIGH, 32'h0007_0001, ASCAN_RESP_OKAY);
      for (int i = 0; i < 9; i++) begin
         step(1'b1, seq1[i], (seq1[i] >= 6'h30) ? ascan_src_t'(seq1[i] - 6'h2F) : ASCAN_SRC_PIN,
              6'(28 + i % 4), ascan_src_t'(i % 4 + 1));
      end
      // last step left input 28 as a pin source, valid
      read_chk(ASCAN_OFS_STATUS, 32'h0000_011C, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_CTRL, 32'h0000_0001, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_LOW, 32'h0, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_HIGH, 32'h0, ASCAN_RESP_OKAY);
      step(1'b0, 6'h00, ASCAN_SRC_PIN, 6'h00, ASCAN_SRC_PIN);
      // requests are refused while disabled
      axi_write(ASCAN_OFS_CTRL, 32'h0, ASCAN_RESP_OKAY);
      axi_write(ASCAN_OFS_LOW, 32'h8000_0005, ASCAN_RESP_OKAY);
      step(1'b0, 6'h00, ASCAN_SRC_PIN, 6'h00, ASCAN_SRC_PIN);
      // re-enable restarts at the lowest input, not above the old position
      axi_write(ASCAN_OFS_CTRL, 32'h1, ASCAN_RESP_OKAY);
      step(1'b1, 6'h00, ASCAN_SRC_PIN, 6'h00, ASCAN_SRC_PIN);
      step(1'b1, 6'h02, ASCAN_SRC_PIN, 6'h02, ASCAN_SRC_PIN);
      // reset in mid-run clears both masks and the scan output
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      read_chk(ASCAN_OFS_LOW, 32'h0, ASCAN_RESP_OKAY);
      read_chk(ASCAN_OFS_HIGH, 32'h0, ASCAN_RESP_OKAY);
      check(32'(scan_valid), 32'h0);
      tally_and_finish();
   end

   // roughly 150 cycles expected; cut a hang well beyond that
   initial begin
      #(40 * 20000);
      n_errors++;
      tally_and_finish();
   end

endmodule
